// ==== design/slc_defines.svh ====
// register map, reset values and field positions of the lamp controller
// assumes it is included by bare name before the package
`ifndef SLC_DEFINES_SVH
`define SLC_DEFINES_SVH

`define SLC_ADR_CTRL      8'h00
`define SLC_ADR_STATUS    8'h04
`define SLC_ADR_IRQ_STAT  8'h08
`define SLC_ADR_IRQ_MASK  8'h0C
`define SLC_ADR_ERRLIST   8'h10

`define SLC_PRESC_RST     16'h03E8
`define SLC_PRESC_W       16
`define SLC_TICK_W        8
`define SLC_STR_W         8
`define SLC_IRQ_W         4

`define SLC_IRQ_NEWERR    0
`define SLC_IRQ_BLOCK     1
`define SLC_IRQ_DRVFLT    2
`define SLC_IRQ_RELAY     3

`define SLC_ERRLIST_VIEW  0

`define SLC_ST_POWER      0
`define SLC_ST_DRIVE      1
`define SLC_ST_FAULT      2
`define SLC_ST_BLOCKED    3
`define SLC_ST_PENDING    4
`define SLC_ST_TX         5
`define SLC_ST_RX         6
`define SLC_ST_ETHSPD     7
`define SLC_ST_ETHLNK     8
`define SLC_ST_BACKUP     9
`define SLC_ST_ECALL      10
`define SLC_ST_RELAY      11
`define SLC_ST_ENC        12
`define SLC_ST_SURED      13
`define SLC_ST_SUGRN      14
`define SLC_ST_WL         15

`endif

// ==== design/slc_lamp_ctrl.sv ====
// front-panel lamp driver of the lift controller and its safety unit
// assumes status inputs come from logic on CLK_I; registers over classic wishbone
// How it works
// [RULE1] power lamp green when supply present and hardware healthy, else dark.
// [RULE2] drive lamp steady green while the drive processor is healthy, dark on fault.
// [RULE3] drive lamp flashes while landing control is off.
// [RULE4] fault lamp steady red while an active error inhibits travel, held until cleared.
// [RULE5] fault lamp flashes when new error-list entries are pending and nothing blocks travel.
// [RULE6] opening the error list clears the flashing indication.
// [RULE7] fault lamp dark with no active error and nothing pending.
// [RULE8] two fieldbus lamps flash, one per sent packet and one per received packet.
// [RULE9] speed lamp dark at 10 Mbit/s and lit at 100 Mbit/s.
// [RULE10] link lamp steady with a link and flashing while frames move.
// [RULE11] wireless lamp green in data modes, orange in command, violet connecting, blue connected.
// [RULE12] backup supply lamp lit while the emergency 24 V feed is present.
// [RULE13] emergency-call lamp red while the call loop is interrupted.
// [RULE14] summary-fault lamp red exactly while the summary fault relay is energised; here the lamp follows the relay one cycle late.
// [RULE15] encoder lamp flashes on sensor communication activity.
// [RULE16] safety status lamp: slow green flash normal, slow red/green teach or install, green start, red error.
// [RULE17] flash rates come from a programmable prescaler; activity lamps are stretched.
//
// Design decisions made here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "slc_defines.svh"

module slc_lamp_ctrl
    import slc_pkg::*;
#(
    parameter int STRETCH_TICKS = 4,
    parameter int FAST_BIT      = 2,
    parameter int SLOW_BIT      = 4
)
(
    input  wire logic                CLK_I,
    input  wire logic                NRST_I,
    input  wire logic                CE_I,
    input  wire logic                CYC_I,
    input  wire logic                STB_I,
    input  wire logic                WE_I,
    input  wire logic [7:0]          ADR_I,
    input  wire logic [3:0]          SEL_I,
    input  wire logic [31:0]         DAT_I,
    output logic [31:0]              DAT_O,
    output logic                     ACK_O,
    output logic                     IRQ_O,
    input  wire logic                SUPPLY_OK_I,
    input  wire logic                HW_OK_I,
    input  wire logic                DRV_OK_I,
    input  wire logic                LANDING_OFF_I,
    input  wire logic                ERR_ACTIVE_I,
    input  wire logic                ERR_CLEAR_I,
    input  wire logic                ERR_NEW_I,
    input  wire logic                ERR_VIEW_I,
    input  wire logic                BUS_TX_I,
    input  wire logic                BUS_RX_I,
    input  wire logic                ETH_LINK_I,
    input  wire logic                ETH_100_I,
    input  wire logic                ETH_ACT_I,
    input  wire slc_wl_mode_e        WL_MODE_I,
    input  wire logic                BACKUP_SUPPLY_I,
    input  wire logic                ECALL_OPEN_I,
    input  wire logic                SUMMARY_FAULT_RELAY_I,
    input  wire logic                ENC_ACT_I,
    input  wire slc_su_mode_e        SU_MODE_I,
    output logic                     TRAVEL_BLOCK_O,
    output logic                     POWER_LAMP_O,
    output logic                     DRIVE_LAMP_O,
    output logic                     FAULT_LAMP_O,
    output logic                     BUS_TX_LAMP_O,
    output logic                     BUS_RX_LAMP_O,
    output logic                     ETH_SPEED_LAMP_O,
    output logic                     ETH_LINK_LAMP_O,
    output logic [2:0]               WL_LAMP_O,
    output logic                     BACKUP_SUPPLY_LAMP_O,
    output logic                     ECALL_LAMP_O,
    output logic                     SUMMARY_FAULT_LAMP_O,
    output logic                     ENC_LAMP_O,
    output logic                     SU_RED_LAMP_O,
    output logic                     SU_GRN_LAMP_O
);

    localparam logic [`SLC_STR_W-1:0] STR_LOAD = `SLC_STR_W'(2 * STRETCH_TICKS);
    localparam logic [`SLC_STR_W-1:0] STR_HALF = `SLC_STR_W'(STRETCH_TICKS);
    localparam slc_rgb_t RGB_GREEN  = 3'h2;
    localparam slc_rgb_t RGB_ORANGE = 3'h6;
    localparam slc_rgb_t RGB_VIOLET = 3'h5;
    localparam slc_rgb_t RGB_BLUE   = 3'h1;
    localparam slc_rgb_t RGB_DARK   = 3'h0;

    // elaboration stops on settings the counters cannot hold
    if (STRETCH_TICKS < 1 || 2 * STRETCH_TICKS >= (1 << `SLC_STR_W))
    begin : g_bad_stretch
        $error("STRETCH_TICKS out of range");
    end
    if (FAST_BIT < 0 || SLOW_BIT >= `SLC_TICK_W || FAST_BIT >= SLOW_BIT)
    begin : g_bad_flash
        $error("flash bit selection out of range");
    end

    // reset release through two flops
    logic       rst_q1;
    logic       rst_n;

    always_ff @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end
        else
        begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    slc_state_s s_reg;
    slc_state_s s_next;

    // retriggers only when idle, so every flash shows a full on and off
    function automatic logic [`SLC_STR_W-1:0] stretch_next(
        input logic [`SLC_STR_W-1:0] cnt,
        input logic                  ev,
        input logic                  tick
    );
        logic [`SLC_STR_W-1:0] r;
        r = cnt;
        if (cnt == '0)
        begin
            if (ev)
                r = STR_LOAD;
        end
        else if (tick)
            r = cnt - `SLC_STR_W'(1);
        return r;
    endfunction

    function automatic logic stretch_on(input logic [`SLC_STR_W-1:0] cnt);
        return cnt > STR_HALF;
    endfunction

    logic                   bus_req;
    logic                   wr;
    logic                   tick;
    logic                   fast_ph;
    logic                   slow_ph;
    logic [`SLC_IRQ_W-1:0]  ev;
    logic [31:0]            st_word;
    logic [31:0]            wmask;

    always_comb
    begin
        s_next  = s_reg;
        bus_req = CYC_I && STB_I && !s_reg.ack;
        // write lands on the edge that sees ack, as the master expects
        wr      = CYC_I && STB_I && WE_I && s_reg.ack;
        wmask   = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};

        // [RULE17] prescaler tick
        tick = (s_reg.pcnt >= s_reg.presc);
        if (tick)
        begin
            s_next.pcnt = '0;
            s_next.tcnt = s_reg.tcnt + `SLC_TICK_W'(1);
        end
        else
            s_next.pcnt = s_reg.pcnt + `SLC_PRESC_W'(1);
        fast_ph = s_reg.tcnt[FAST_BIT];
        slow_ph = s_reg.tcnt[SLOW_BIT];

        // [RULE4] travel block held until cleared
        if (ERR_ACTIVE_I)
            s_next.blocked = 1'b1;
        else if (ERR_CLEAR_I)
            s_next.blocked = 1'b0;

        // [RULE6] viewing clears pending; a new entry wins
        if (ERR_VIEW_I || (wr && ADR_I == `SLC_ADR_ERRLIST
                           && SEL_I[0] && DAT_I[`SLC_ERRLIST_VIEW]))
            s_next.pending = 1'b0;
        if (ERR_NEW_I)
            s_next.pending = 1'b1;

        // [RULE8] fieldbus activity stretch
        s_next.str_tx  = stretch_next(s_reg.str_tx, BUS_TX_I, tick);
        s_next.str_rx  = stretch_next(s_reg.str_rx, BUS_RX_I, tick);
        // [RULE10] frame activity stretch
        s_next.str_eth = stretch_next(s_reg.str_eth, ETH_ACT_I, tick);
        // [RULE15] encoder activity stretch
        s_next.str_enc = stretch_next(s_reg.str_enc, ENC_ACT_I, tick);

        s_next.drv_ok_q = DRV_OK_I;
        s_next.relay_q  = SUMMARY_FAULT_RELAY_I;
        ev = '0;
        ev[`SLC_IRQ_NEWERR] = ERR_NEW_I;
        ev[`SLC_IRQ_BLOCK]  = s_next.blocked && !s_reg.blocked;
        ev[`SLC_IRQ_DRVFLT] = s_reg.drv_ok_q && !DRV_OK_I;
        ev[`SLC_IRQ_RELAY]  = SUMMARY_FAULT_RELAY_I && !s_reg.relay_q;

        // lamps
        // [RULE1] power lamp
        s_next.l_power = SUPPLY_OK_I && HW_OK_I;
        // [RULE2] drive lamp
        // [RULE3] flash when landing control off
        s_next.l_drive = DRV_OK_I && (!LANDING_OFF_I || fast_ph);
        // [RULE4] steady red when blocked
        // [RULE5] flash on pending entries
        // [RULE7] dark otherwise
        if (s_next.blocked)
            s_next.l_fault = 1'b1;
        else if (s_next.pending)
            s_next.l_fault = fast_ph;
        else
            s_next.l_fault = 1'b0;
        // [RULE8] packet lamps
        s_next.l_tx = stretch_on(s_reg.str_tx);
        s_next.l_rx = stretch_on(s_reg.str_rx);
        // [RULE9] speed lamp
        s_next.l_eth_spd = ETH_100_I;
        // [RULE10] link lamp, blinks while traffic
        s_next.l_eth_lnk = ETH_LINK_I && !(s_reg.str_eth != '0 && !stretch_on(s_reg.str_eth));
        // [RULE11] wireless colour
        case (WL_MODE_I)
            SLC_WL_DATA:    s_next.l_wl = RGB_GREEN;
            SLC_WL_EXTDATA: s_next.l_wl = RGB_GREEN;
            SLC_WL_CMD:     s_next.l_wl = RGB_ORANGE;
            SLC_WL_CONNING: s_next.l_wl = RGB_VIOLET;
            SLC_WL_CONNED:  s_next.l_wl = RGB_BLUE;
            default:        s_next.l_wl = RGB_DARK;
        endcase
        // [RULE12] backup supply lamp
        s_next.l_backup = BACKUP_SUPPLY_I;
        // [RULE13] call loop lamp
        s_next.l_ecall = ECALL_OPEN_I;
        // [RULE14] one cycle behind the relay, no filtering
        s_next.l_relay = SUMMARY_FAULT_RELAY_I;
        // [RULE15] encoder lamp
        s_next.l_enc = stretch_on(s_reg.str_enc);
        // [RULE16] safety unit status
        case (SU_MODE_I)
            SLC_SU_START:
            begin
                s_next.l_su_red = 1'b0;
                s_next.l_su_grn = 1'b1;
            end
            SLC_SU_NORMAL:
            begin
                s_next.l_su_red = 1'b0;
                s_next.l_su_grn = slow_ph;
            end
            SLC_SU_TEACH, SLC_SU_INSTALL:
            begin
                s_next.l_su_red = !slow_ph;
                s_next.l_su_grn = slow_ph;
            end
            default:
            begin
                s_next.l_su_red = 1'b1;
                s_next.l_su_grn = 1'b0;
            end
        endcase

        st_word = '0;
        st_word[`SLC_ST_POWER]   = s_reg.l_power;
        st_word[`SLC_ST_DRIVE]   = s_reg.l_drive;
        st_word[`SLC_ST_FAULT]   = s_reg.l_fault;
        st_word[`SLC_ST_BLOCKED] = s_reg.blocked;
        st_word[`SLC_ST_PENDING] = s_reg.pending;
        st_word[`SLC_ST_TX]      = s_reg.l_tx;
        st_word[`SLC_ST_RX]      = s_reg.l_rx;
        st_word[`SLC_ST_ETHSPD]  = s_reg.l_eth_spd;
        st_word[`SLC_ST_ETHLNK]  = s_reg.l_eth_lnk;
        st_word[`SLC_ST_BACKUP]  = s_reg.l_backup;
        st_word[`SLC_ST_ECALL]   = s_reg.l_ecall;
        st_word[`SLC_ST_RELAY]   = s_reg.l_relay;
        st_word[`SLC_ST_ENC]     = s_reg.l_enc;
        st_word[`SLC_ST_SURED]   = s_reg.l_su_red;
        st_word[`SLC_ST_SUGRN]   = s_reg.l_su_grn;
        st_word[`SLC_ST_WL +: 3] = s_reg.l_wl;

        // wishbone: answer one cycle after the strobe, unmapped reads zero
        s_next.ack  = bus_req;
        s_next.rdat = '0;
        if (bus_req && !WE_I)
        begin
            if (ADR_I == `SLC_ADR_CTRL)
                s_next.rdat = {16'h0000, s_reg.presc};
            else if (ADR_I == `SLC_ADR_STATUS)
                s_next.rdat = st_word;
            else if (ADR_I == `SLC_ADR_IRQ_STAT)
                s_next.rdat = {28'h0000000, s_reg.irq_stat};
            else if (ADR_I == `SLC_ADR_IRQ_MASK)
                s_next.rdat = {28'h0000000, s_reg.irq_mask};
            else
                s_next.rdat = '0;
        end

        // sticky events; write one clears, a fresh event wins
        s_next.irq_stat = s_reg.irq_stat;
        if (wr)
        begin
            if (ADR_I == `SLC_ADR_CTRL)
                s_next.presc = (s_reg.presc & ~wmask[15:0]) | (DAT_I[15:0] & wmask[15:0]);
            else if (ADR_I == `SLC_ADR_IRQ_STAT && SEL_I[0])
                s_next.irq_stat = s_reg.irq_stat & ~DAT_I[`SLC_IRQ_W-1:0];
            else if (ADR_I == `SLC_ADR_IRQ_MASK && SEL_I[0])
                s_next.irq_mask = DAT_I[`SLC_IRQ_W-1:0];
        end
        s_next.irq_stat = s_next.irq_stat | ev;
        s_next.irq      = |(s_next.irq_stat & s_next.irq_mask);
    end

    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_reg       <= '0;
            s_reg.presc <= `SLC_PRESC_RST;
        end
        else if (CE_I)
            s_reg <= s_next;
    end

    assign DAT_O                = s_reg.rdat;
    assign ACK_O                = s_reg.ack;
    assign IRQ_O                = s_reg.irq;
    assign TRAVEL_BLOCK_O       = s_reg.blocked;
    assign POWER_LAMP_O         = s_reg.l_power;
    assign DRIVE_LAMP_O         = s_reg.l_drive;
    assign FAULT_LAMP_O         = s_reg.l_fault;
    assign BUS_TX_LAMP_O        = s_reg.l_tx;
    assign BUS_RX_LAMP_O        = s_reg.l_rx;
    assign ETH_SPEED_LAMP_O     = s_reg.l_eth_spd;
    assign ETH_LINK_LAMP_O      = s_reg.l_eth_lnk;
    assign WL_LAMP_O            = s_reg.l_wl;
    assign BACKUP_SUPPLY_LAMP_O = s_reg.l_backup;
    assign ECALL_LAMP_O         = s_reg.l_ecall;
    assign SUMMARY_FAULT_LAMP_O = s_reg.l_relay;
    assign ENC_LAMP_O           = s_reg.l_enc;
    assign SU_RED_LAMP_O        = s_reg.l_su_red;
    assign SU_GRN_LAMP_O        = s_reg.l_su_grn;

endmodule
`default_nettype wire

// ==== design/slc_pkg.sv ====
// types shared by the lamp controller
// assumes slc_defines.svh is on the include path
`include "slc_defines.svh"

package slc_pkg;

    typedef enum logic [5:0] {
        SLC_WL_OFF     = 6'h01,
        SLC_WL_DATA    = 6'h02,
        SLC_WL_EXTDATA = 6'h04,
        SLC_WL_CMD     = 6'h08,
        SLC_WL_CONNING = 6'h10,
        SLC_WL_CONNED  = 6'h20
    } slc_wl_mode_e;

    typedef enum logic [4:0] {
        SLC_SU_START   = 5'h01,
        SLC_SU_NORMAL  = 5'h02,
        SLC_SU_TEACH   = 5'h04,
        SLC_SU_INSTALL = 5'h08,
        SLC_SU_ERROR   = 5'h10
    } slc_su_mode_e;

    // red, green, blue
    typedef logic [2:0] slc_rgb_t;

    typedef struct packed {
        logic                      ack;
        logic [31:0]               rdat;
        logic [`SLC_PRESC_W-1:0]   presc;
        logic [`SLC_PRESC_W-1:0]   pcnt;
        logic [`SLC_TICK_W-1:0]    tcnt;
        logic [`SLC_IRQ_W-1:0]     irq_stat;
        logic [`SLC_IRQ_W-1:0]     irq_mask;
        logic                      irq;
        logic                      blocked;
        logic                      pending;
        logic                      drv_ok_q;
        logic                      relay_q;
        logic [`SLC_STR_W-1:0]     str_tx;
        logic [`SLC_STR_W-1:0]     str_rx;
        logic [`SLC_STR_W-1:0]     str_eth;
        logic [`SLC_STR_W-1:0]     str_enc;
        logic                      l_power;
        logic                      l_drive;
        logic                      l_fault;
        logic                      l_tx;
        logic                      l_rx;
        logic                      l_eth_spd;
        logic                      l_eth_lnk;
        slc_rgb_t                  l_wl;
        logic                      l_backup;
        logic                      l_ecall;
        logic                      l_relay;
        logic                      l_enc;
        logic                      l_su_red;
        logic                      l_su_grn;
    } slc_state_s;

endpackage

// ==== verification/slc_lamp_sva.sv ====
// assertions on the lamp controller ports
// checks pause while CE_I is low; checks start once reset has settled
`timescale 1ns/1ps
`default_nettype none
module slc_lamp_sva
    import slc_pkg::*;
(
    input wire logic         CLK_I,
    input wire logic         NRST_I,
    input wire logic         CE_I,
    input wire logic         CYC_I,
    input wire logic         STB_I,
    input wire logic         ACK_O,
    input wire logic         SUPPLY_OK_I,
    input wire logic         HW_OK_I,
    input wire logic         DRV_OK_I,
    input wire logic         LANDING_OFF_I,
    input wire logic         BUS_TX_I,
    input wire slc_wl_mode_e WL_MODE_I,
    input wire slc_su_mode_e SU_MODE_I,
    input wire logic         POWER_LAMP_O,
    input wire logic         DRIVE_LAMP_O,
    input wire logic         BUS_TX_LAMP_O,
    input wire logic [2:0]   WL_LAMP_O,
    input wire logic         SU_RED_LAMP_O,
    input wire logic         SU_GRN_LAMP_O
);
    logic [2:0] up_reg;
    logic       ok;
    logic [2:0] wl_exp;

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!NRST_I);

    // sync reset stage and first update must pass before lamps follow inputs
    always_ff @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            up_reg <= 3'h0;
        else if (!CE_I)
            up_reg <= 3'h0;
        else if (up_reg != 3'h5)
            up_reg <= up_reg + 3'h1;
    end
    assign ok = (up_reg == 3'h5);

    always_comb
    begin
        case (WL_MODE_I)
            SLC_WL_DATA, SLC_WL_EXTDATA: wl_exp = 3'h2;
            SLC_WL_CMD:                  wl_exp = 3'h6;
            SLC_WL_CONNING:              wl_exp = 3'h5;
            SLC_WL_CONNED:               wl_exp = 3'h1;
            default:                     wl_exp = 3'h0;
        endcase
    end

    property p_power; ok |-> POWER_LAMP_O == $past(SUPPLY_OK_I && HW_OK_I); endproperty
    a_power: assert property (p_power) else $error("power lamp wrong");
    property p_drv_dark; ok && !$past(DRV_OK_I) |-> !DRIVE_LAMP_O; endproperty
    a_drv_dark: assert property (p_drv_dark) else $error("drive lamp lit on fault");
    property p_drv_on; ok && $past(DRV_OK_I && !LANDING_OFF_I) |-> DRIVE_LAMP_O; endproperty
    a_drv_on: assert property (p_drv_on) else $error("drive lamp not steady");
    property p_tx_rise; ok && $rose(BUS_TX_LAMP_O) |-> $past(BUS_TX_I) || $past(BUS_TX_I, 2); endproperty
    a_tx_rise: assert property (p_tx_rise) else $error("tx lamp lit without packet");
    property p_wl; ok |-> WL_LAMP_O == $past(wl_exp); endproperty
    a_wl: assert property (p_wl) else $error("wireless colour wrong");
    property p_su_start; ok && $past(SU_MODE_I == SLC_SU_START) |-> SU_GRN_LAMP_O && !SU_RED_LAMP_O; endproperty
    a_su_start: assert property (p_su_start) else $error("start colour wrong");
    property p_su_alt; ok && $past(SU_MODE_I == SLC_SU_TEACH) |-> SU_RED_LAMP_O != SU_GRN_LAMP_O; endproperty
    a_su_alt: assert property (p_su_alt) else $error("teach lamps not alternating");
    property p_ack; ok && CE_I && CYC_I && STB_I && !ACK_O |=> ACK_O ##1 !ACK_O; endproperty
    a_ack: assert property (p_ack) else $error("bus answer not one cycle");

    cover property (ok && $rose(DRIVE_LAMP_O) && LANDING_OFF_I);
    cover property (ok && SU_RED_LAMP_O && SU_MODE_I == SLC_SU_TEACH);
    cover property (ok && ACK_O);
endmodule

bind slc_lamp_ctrl slc_lamp_sva u_sva (
    .CLK_I(CLK_I), .NRST_I(NRST_I), .CE_I(CE_I), .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O),
    .SUPPLY_OK_I(SUPPLY_OK_I), .HW_OK_I(HW_OK_I), .DRV_OK_I(DRV_OK_I), .LANDING_OFF_I(LANDING_OFF_I),
    .BUS_TX_I(BUS_TX_I), .WL_MODE_I(WL_MODE_I), .SU_MODE_I(SU_MODE_I), .POWER_LAMP_O(POWER_LAMP_O),
    .DRIVE_LAMP_O(DRIVE_LAMP_O), .BUS_TX_LAMP_O(BUS_TX_LAMP_O), .WL_LAMP_O(WL_LAMP_O),
    .SU_RED_LAMP_O(SU_RED_LAMP_O), .SU_GRN_LAMP_O(SU_GRN_LAMP_O)
);
`default_nettype wire

// ==== verification/test_slc_lamp_ctrl.sv ====
// self-checking bench of the lamp controller
// assumes one 200 MHz clock and a classic wishbone master
`timescale 1ns/1ps
`default_nettype none
`include "slc_defines.svh"
module test_slc_lamp_ctrl
    import slc_pkg::*;
;
    logic         clk, nrst, ce, cyc, stb, we, ack, irq, blk, lp, lsp, lbk, lec, lrl;
    logic         ld, lf, ltx, lrx, llk, len, lsr, lsg;
    logic [2:0]   lwl;
    logic [3:0]   sel;
    logic [7:0]   adr, obs;
    logic [31:0]  dat, dat_o, q;
    logic [9:0]   lv;
    logic [6:0]   pl;
    logic [15:0]  sv;
    slc_wl_mode_e wl;
    slc_su_mode_e su;
    int           num_errors = 0;
    int           n_compared = 0;

    assign obs = {len, llk, lrx, ltx, lsg, lsr, lf, ld};

    slc_lamp_ctrl u_dut (
        .CLK_I(clk), .NRST_I(nrst), .CE_I(ce), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
        .SEL_I(sel), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack), .IRQ_O(irq),
        .SUPPLY_OK_I(lv[0]), .HW_OK_I(lv[1]), .DRV_OK_I(lv[2]), .LANDING_OFF_I(lv[3]), .ERR_ACTIVE_I(lv[4]),
        .ERR_CLEAR_I(pl[0]), .ERR_NEW_I(pl[1]), .ERR_VIEW_I(pl[2]), .BUS_TX_I(pl[3]), .BUS_RX_I(pl[4]),
        .ETH_LINK_I(lv[5]), .ETH_100_I(lv[6]), .ETH_ACT_I(pl[5]), .WL_MODE_I(wl), .BACKUP_SUPPLY_I(lv[7]),
        .ECALL_OPEN_I(lv[8]), .SUMMARY_FAULT_RELAY_I(lv[9]), .ENC_ACT_I(pl[6]), .SU_MODE_I(su),
        .TRAVEL_BLOCK_O(blk), .POWER_LAMP_O(lp), .DRIVE_LAMP_O(ld), .FAULT_LAMP_O(lf), .BUS_TX_LAMP_O(ltx),
        .BUS_RX_LAMP_O(lrx), .ETH_SPEED_LAMP_O(lsp), .ETH_LINK_LAMP_O(llk), .WL_LAMP_O(lwl),
        .BACKUP_SUPPLY_LAMP_O(lbk), .ECALL_LAMP_O(lec), .SUMMARY_FAULT_LAMP_O(lrl), .ENC_LAMP_O(len),
        .SU_RED_LAMP_O(lsr), .SU_GRN_LAMP_O(lsg)
    );

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cy(input int k);
        repeat (k) @(posedge clk);
    endtask

    // waits for ack with no assumed latency; the bound only catches a dead bus
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hF};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        q = dat_o;
        if (n >= 50)
            num_errors++;
        {cyc, stb, we} <= 3'b000;
    endtask

    task automatic set(input int i, input logic b);
        @(posedge clk);
        lv[i] <= b;
        cy(3);
    endtask

    task automatic pulse(input int i);
        @(posedge clk);
        pl[i] <= 1'b1;
        @(posedge clk);
        pl[i] <= 1'b0;
    endtask

    // records, per lamp, whether it was seen dark and seen lit
    task automatic seen(input int k);
        sv = '0;
        repeat (k)
        begin
            @(posedge clk);
            for (int j = 0; j < 8; j++)
                if (!$isunknown(obs[j])) sv[2*j + obs[j]] = 1'b1;
        end
    endtask

    initial
    begin
        slc_wl_mode_e wm [6];
        logic [2:0]   wx [6];
        slc_su_mode_e sm [5];
        logic [3:0]   sx [5];
        wm = '{SLC_WL_OFF, SLC_WL_DATA, SLC_WL_EXTDATA, SLC_WL_CMD, SLC_WL_CONNING, SLC_WL_CONNED};
        wx = '{3'h0, 3'h2, 3'h2, 3'h6, 3'h5, 3'h1};
        sm = '{SLC_SU_START, SLC_SU_NORMAL, SLC_SU_TEACH, SLC_SU_INSTALL, SLC_SU_ERROR};
        sx = '{4'h9, 4'hD, 4'hF, 4'hF, 4'h6};
        {cyc, stb, we, adr, dat, sel, lv, pl} = '0;
        ce = 1'b1;
        wl = SLC_WL_OFF;
        su = SLC_SU_START;
        nrst = 1'b0;
        cy(2);
        nrst <= 1'b1;
        cy(3);
        wb(1'b0, `SLC_ADR_CTRL, 32'h0);
        chk(q, `SLC_PRESC_RST);
        // fastest flashing keeps the run short
        wb(1'b1, `SLC_ADR_CTRL, 32'h0);
        wb(1'b0, `SLC_ADR_CTRL, 32'h0);
        chk(q, 32'h0);
        wb(1'b0, 8'h20, 32'h0);
        chk(q, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            set(0, i[0]);
            set(1, i[1]);
            chk(lp, i == 3);
        end
        // clock enable low freezes the lamp
        ce <= 1'b0;
        set(0, 1'b0);
        chk(lp, 1'b1);
        ce <= 1'b1;
        cy(3);
        chk(lp, 1'b0);
        set(0, 1'b1);
        set(2, 1'b1);
        seen(64);
        chk(sv[1:0], 2'b10);
        set(3, 1'b1);
        seen(64);
        chk(sv[1:0], 2'b11);
        set(3, 1'b0);
        seen(64);
        chk(sv[1:0], 2'b10);
        set(2, 1'b0);
        seen(64);
        chk(sv[1:0], 2'b01);
        set(4, 1'b1);
        pulse(1);
        seen(40);
        chk({blk, sv[3:2]}, 3'b110);
        set(4, 1'b0);
        chk({blk, lf}, 2'b11);
        pulse(0);
        seen(64);
        chk({blk, sv[3:2]}, 3'b011);
        wb(1'b1, `SLC_ADR_ERRLIST, 32'h1);
        cy(3);
        seen(40);
        chk(sv[3:2], 2'b01);
        pulse(1);
        pulse(2);
        cy(3);
        seen(40);
        chk(sv[3:2], 2'b01);
        wb(1'b0, `SLC_ADR_IRQ_STAT, 32'h0);
        chk({irq, q[0]}, 2'b01);
        wb(1'b1, `SLC_ADR_IRQ_MASK, 32'h1);
        cy(3);
        chk(irq, 1'b1);
        wb(1'b1, `SLC_ADR_IRQ_STAT, 32'h1);
        cy(3);
        chk(irq, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            if (i == 2)
                continue;
            pulse(3 + i);
            seen(30);
            chk({obs[4 + i], sv[2*(4 + i) +: 2]}, 3'b011);
        end
        set(5, 1'b1);
        chk(llk, 1'b1);
        pulse(5);
        seen(30);
        chk(sv[13:12], 2'b11);
        for (int b = 1; b >= 0; b--)
        begin
            set(6, b[0]);
            chk(lsp, b);
            set(7, b[0]);
            set(8, b[0]);
            set(9, b[0]);
            chk({lrl, lec, lbk}, {3{b[0]}});
            wb(1'b0, `SLC_ADR_STATUS, 32'h0);
            chk(q[11:9], {3{b[0]}});
        end
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clk);
            wl <= wm[i];
            cy(3);
            chk(lwl, wx[i]);
        end
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk);
            su <= sm[i];
            cy(3);
            seen(80);
            chk(sv[7:4], sx[i]);
        end
        give_verdict();
    end

    // whole sequence needs about 1200 cycles; over thirty times that means a hang
    initial
    begin
        repeat (40000) @(posedge clk);
        num_errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
